//--- rtl/epo_defs.svh
// constants for the encoder pulse output and absolute start-up sequence
// assumes a single 125 MHz clock shared by both ends
`ifndef EPO_DEFS_SVH
`define EPO_DEFS_SVH
`define EPO_CLK_MHZ         125
`define EPO_PITCH_DEF       32'h0000_8000
`define EPO_PITCH_MIN       32'h0000_0004
`define EPO_PITCH_MAX       32'h0010_0000
`define EPO_RES_DEF         13'h0014
`define EPO_RES_MAX         13'h1000
`define EPO_SERIAL_UNIT     32'h0010_0000
`define EPO_CHAR_COUNT      4'h8
`define EPO_BAUD            9600
`define EPO_BIT_CYC         (1000000 * `EPO_CLK_MHZ / `EPO_BAUD)
`define EPO_RATE_MAX_KPPS   6400
`define EPO_EDGE_MIN_CYC    ((1000 * `EPO_CLK_MHZ + `EPO_RATE_MAX_KPPS - 1) / `EPO_RATE_MAX_KPPS)
`define EPO_INIT_PULSE_NS   1480
`define EPO_INIT_PULSE_CYC  (`EPO_INIT_PULSE_NS * `EPO_CLK_MHZ / 1000)
`define EPO_SETTLE_MS       400
`define EPO_SETTLE_CYC      (`EPO_SETTLE_MS * 1000 * `EPO_CLK_MHZ)
`define EPO_WAIT_MS         100
`define EPO_WAIT_CYC        (`EPO_WAIT_MS * 1000 * `EPO_CLK_MHZ)
`define EPO_USE_NONE        2'h0
`define EPO_USE_FWD         2'h1
`define EPO_USE_REV         2'h3
`endif

//--- rtl/epo_device.sv
// device end: divides encoder motion into quadrature, origin pulse,
// and runs the absolute start-up sequence on channel a
// assumes encoder step/direction inputs already in this clock domain
`timescale 1ns/1ns
`default_nettype none
`include "epo_defs.svh"
module epo_device
    import epo_pkg::*;
#(
    parameter int          SETTLE_CYC  = `EPO_SETTLE_CYC,
    parameter int          BIT_CYC     = `EPO_BIT_CYC,
    parameter logic [31:0] PITCH_COUNT = `EPO_PITCH_DEF,
    parameter logic [12:0] RESOLUTION  = `EPO_RES_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst,
    epo_link_if.device       link,
    input  wire logic        rotation_direction_select,
    input  wire logic [1:0]  external_encoder_usage,
    input  wire epo_align_t  origin_align,
    input  wire logic        absolute_encoder,
    input  wire logic        enc_step,
    input  wire logic        enc_sin_lead,
    input  wire logic        enc_origin,
    input  wire logic [31:0] abs_position,
    output logic             rate_alarm,
    output logic             normal_mode,
    output logic             usage_error
);
    typedef enum logic [2:0] {ST_IDLE, ST_SERIAL, ST_PULSES, ST_SETTLE, ST_NORMAL} epo_st_t;
    // settings latched at the end of reset; restart applies new ones
    logic [31:0] pitch_ff;
    logic [12:0] res_ff;
    logic        cfg_done_ff;
    // request synchroniser
    logic        req_s1_ff, req_s2_ff;
    // sequencer state
    epo_st_t     st_ff, nxt_st;
    logic [31:0] tmr_ff, nxt_tmr;      // bit/pulse/settle timer
    logic [3:0]  bit_ff, nxt_bit;      // bit inside a character
    logic [3:0]  chr_ff, nxt_chr;      // characters sent
    logic [63:0] ser_ff, nxt_ser;      // serial value shift
    logic [20:0] rem_ff, nxt_rem;      // initial pulses left
    // quadrature generator
    logic [1:0]  ph_ff, nxt_ph;        // gray phase 00,01,11,10
    logic [31:0] acc_ff, nxt_acc;      // edge-per-pitch accumulator
    logic [7:0]  gap_ff, nxt_gap;      // cycles since last edge
    logic        a_ff, nxt_a, b_ff, nxt_b, c_ff, nxt_c;
    logic        alarm_ff, nxt_alarm;
    logic        org_seen_ff, nxt_org_seen;
    logic        org_arm_ff, nxt_org_arm;
    logic        fwd;                  // motion maps to forward reference
    logic        edge_req;             // one output edge due this cycle
    logic [31:0] acc_sum;
    logic [1:0]  ph_new;
    ////////////////////////////////////////////////////////////////////
    // config capture and request sync
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pitch_ff    <= `EPO_PITCH_DEF;
            res_ff      <= `EPO_RES_DEF;
            cfg_done_ff <= 1'b0;
            req_s1_ff   <= 1'b0;
            req_s2_ff   <= 1'b0;
        end
        else
        begin
            if (!cfg_done_ff)
            begin
                // clamp to legal range at restart
                pitch_ff <= (PITCH_COUNT < `EPO_PITCH_MIN) ? `EPO_PITCH_MIN :
                            (PITCH_COUNT > `EPO_PITCH_MAX) ? `EPO_PITCH_MAX : PITCH_COUNT;
                res_ff   <= (RESOLUTION == 13'h0000) ? 13'h0001 :
                            (RESOLUTION > `EPO_RES_MAX) ? `EPO_RES_MAX : RESOLUTION;
            end
            cfg_done_ff <= 1'b1;
            req_s1_ff   <= link.absolute_data_request;
            req_s2_ff   <= req_s1_ff;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        // cos lead is forward at usage 1, select 0; usage 3 and select each flip it
        fwd = ~enc_sin_lead ^ (external_encoder_usage == `EPO_USE_REV)
              ^ rotation_direction_select;
        // each pitch queues res edges; one leaves per rate-limit spacing
        edge_req = (|acc_ff) && (gap_ff >= 8'(`EPO_EDGE_MIN_CYC - 1));
        acc_sum  = acc_ff - {31'h0, edge_req};
        nxt_acc  = acc_sum;
        if (st_ff == ST_NORMAL && enc_step)
            nxt_acc = acc_sum + 32'(res_ff);
        // forward: b leads a, sequence 00->01->11->10
        ph_new  = fwd ? {ph_ff[0], ~ph_ff[1]} : {~ph_ff[0], ph_ff[1]};
        nxt_ph  = edge_req ? ph_new : ph_ff;
        nxt_gap = edge_req ? 8'h00 : ((gap_ff == 8'hff) ? gap_ff : gap_ff + 8'h01);
        // sticky alarm when a pitch arrives before its edges could leave
        nxt_alarm = alarm_ff || (enc_step && st_ff == ST_NORMAL && (|acc_ff));
        // origin: first crossing only for absolute, every crossing otherwise
        nxt_org_seen = org_seen_ff || (enc_origin && st_ff == ST_NORMAL);
        nxt_org_arm  = org_arm_ff;
        if (enc_origin && st_ff == ST_NORMAL && !(absolute_encoder && org_seen_ff))
            nxt_org_arm = 1'b1;
        nxt_c = c_ff;
        if (edge_req)
        begin
            // c rises on the chosen edge and falls on the next falling edge of a
            unique case (origin_align)
                EPO_ALIGN_A_RISE: if (!ph_ff[1] && ph_new[1] && org_arm_ff) nxt_c = 1'b1;
                EPO_ALIGN_A_FALL: if (ph_ff[1] && !ph_new[1] && org_arm_ff) nxt_c = 1'b1;
                EPO_ALIGN_B_RISE: if (!ph_ff[0] && ph_new[0] && org_arm_ff) nxt_c = 1'b1;
                EPO_ALIGN_B_FALL: if (ph_ff[0] && !ph_new[0] && org_arm_ff) nxt_c = 1'b1;
            endcase
            if (nxt_c && !c_ff)
                nxt_org_arm = 1'b0;
            else if (c_ff && ph_new[1] != ph_ff[1] && ph_new[1] == 1'b0)
                nxt_c = 1'b0;
        end
        // sequencer
        nxt_st  = st_ff;
        nxt_tmr = (tmr_ff == 32'h0000_0000) ? tmr_ff : tmr_ff - 32'h0000_0001;
        nxt_bit = bit_ff;
        nxt_chr = chr_ff;
        nxt_ser = ser_ff;
        nxt_rem = rem_ff;
        nxt_a   = nxt_ph[1];
        nxt_b   = nxt_ph[0];
        unique case (st_ff)
            ST_IDLE:
            begin
                nxt_a = 1'b1;
                nxt_b = 1'b0;
                if (req_s2_ff && cfg_done_ff)
                begin
                    // serial unit count and remainder of position
                    nxt_ser = {32'h0000_0000, abs_position >> 20};
                    nxt_rem = 21'(abs_position & (`EPO_SERIAL_UNIT - 32'h1));
                    nxt_st  = ST_SERIAL;
                    nxt_bit = 4'h0;
                    nxt_chr = 4'h0;
                    nxt_tmr = 32'(BIT_CYC - 1);
                end
            end
            ST_SERIAL:
            begin
                // 8N1 frame: start, 8 data lsb first, stop
                nxt_a = (bit_ff == 4'h0) ? 1'b0 :
                        (bit_ff == 4'h9) ? 1'b1 : ser_ff[bit_ff - 4'h1];
                nxt_b = 1'b0;
                if (tmr_ff == 32'h0000_0000)
                begin
                    nxt_tmr = 32'(BIT_CYC - 1);
                    if (bit_ff == 4'h9)
                    begin
                        nxt_bit = 4'h0;
                        nxt_ser = ser_ff >> 8;
                        nxt_chr = chr_ff + 4'h1;
                        if (chr_ff == `EPO_CHAR_COUNT - 4'h1)
                        begin
                            nxt_st  = ST_PULSES;
                            nxt_tmr = 32'(`EPO_INIT_PULSE_CYC - 1);
                        end
                    end
                    else
                        nxt_bit = bit_ff + 4'h1;
                end
            end
            ST_PULSES:
            begin
                // one pulse on a per period, high half then low
                nxt_a = (rem_ff == 21'h0) || (tmr_ff >= 32'(`EPO_INIT_PULSE_CYC / 2));
                nxt_b = 1'b0;
                if (rem_ff == 21'h0)
                begin
                    nxt_st  = ST_SETTLE;
                    nxt_tmr = 32'(SETTLE_CYC);
                end
                else if (tmr_ff == 32'h0000_0000)
                begin
                    nxt_rem = rem_ff - 21'h1;
                    nxt_tmr = 32'(`EPO_INIT_PULSE_CYC - 1);
                end
            end
            ST_SETTLE:
            begin
                nxt_a = 1'b1;
                nxt_b = 1'b0;
                if (tmr_ff == 32'h0000_0000)
                    nxt_st = ST_NORMAL;
            end
            ST_NORMAL:
            begin
                if (!req_s2_ff)
                    nxt_st = ST_NORMAL;
            end
        endcase
        if (st_ff != ST_NORMAL)
            nxt_c = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff       <= ST_IDLE;
            tmr_ff      <= 32'h0000_0000;
            bit_ff      <= 4'h0;
            chr_ff      <= 4'h0;
            ser_ff      <= 64'h0;
            rem_ff      <= 21'h0;
            ph_ff       <= 2'b11;
            acc_ff      <= 32'h0000_0000;
            gap_ff      <= 8'hff;
            a_ff        <= 1'b1;
            b_ff        <= 1'b0;
            c_ff        <= 1'b0;
            alarm_ff    <= 1'b0;
            org_seen_ff <= 1'b0;
            org_arm_ff  <= 1'b0;
            usage_error <= 1'b0;
            normal_mode <= 1'b0;
        end
        else
        begin
            st_ff       <= nxt_st;
            tmr_ff      <= nxt_tmr;
            bit_ff      <= nxt_bit;
            chr_ff      <= nxt_chr;
            ser_ff      <= nxt_ser;
            rem_ff      <= nxt_rem;
            ph_ff       <= nxt_ph;
            acc_ff      <= nxt_acc;
            gap_ff      <= nxt_gap;
            a_ff        <= nxt_a;
            b_ff        <= nxt_b;
            c_ff        <= nxt_c;
            alarm_ff    <= nxt_alarm;
            org_seen_ff <= nxt_org_seen;
            org_arm_ff  <= nxt_org_arm;
            // 0 and 2 are not a closed-loop sense here
            usage_error <= (external_encoder_usage != `EPO_USE_FWD) &&
                           (external_encoder_usage != `EPO_USE_REV);
            normal_mode <= (nxt_st == ST_NORMAL);
        end
    end
    assign link.quad_out_a       = a_ff;
    assign link.quad_out_b       = b_ff;
    assign link.origin_pulse_out = c_ff;
    assign rate_alarm            = alarm_ff;
endmodule
`default_nettype wire

//--- rtl/epo_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock, asynchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module epo_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];   // storage
    logic [AW-1:0]    wr_ff, nxt_wr;    // write pointer
    logic [AW-1:0]    rd_ff, nxt_rd;    // read pointer
    logic [AW:0]      cnt_ff, nxt_cnt;  // fill level
    logic             push, pop;
    ////////////////////////////////////////////////////////////////////
    // flags and next pointers
    always_comb
    begin
        in_ready  = (cnt_ff != AW'(0) + (AW+1)'(DEPTH));
        out_valid = (cnt_ff != '0);
        out_data  = mem_ff[rd_ff];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        nxt_wr    = push ? AW'(wr_ff + 1'b1) : wr_ff;
        nxt_rd    = pop ? AW'(rd_ff + 1'b1) : rd_ff;
        nxt_cnt   = (AW+1)'(cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
    // registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end
    // storage has no reset
    always_ff @(posedge clk)
    begin
        if (push)
            mem_ff[wr_ff] <= in_data;
    end
endmodule
`default_nettype wire

//--- rtl/epo_host.sv
// host end: raises request, receives 8 characters, counts initial and
// normal quadrature pulses, rebuilds position; bytes pass a fifo
// assumes link pins come from the device and are synchronised here
`timescale 1ns/1ns
`default_nettype none
`include "epo_defs.svh"
module epo_host
    import epo_pkg::*;
#(
    parameter int WAIT_CYC = `EPO_WAIT_CYC,
    parameter int BIT_CYC  = `EPO_BIT_CYC,
    parameter int DEPTH    = 32
) (
    input  wire logic        clk,
    input  wire logic        rst,
    epo_link_if.host         link,
    input  wire logic        start,
    input  wire logic [63:0] ref_serial,
    input  wire logic [31:0] ref_pulses,
    output logic [63:0] user_position,
    output logic        position_valid,
    output logic [7:0]  rx_byte,
    output logic        rx_byte_valid,
    input  wire logic   rx_byte_ready
);
    typedef enum logic [2:0] {HS_IDLE, HS_WAIT, HS_RX, HS_PULSE, HS_RUN} epo_hs_t;
    logic        a1_ff, a2_ff, b1_ff, b2_ff, a3_ff, b3_ff;
    epo_hs_t     st_ff, nxt_st;
    logic [31:0] tmr_ff, nxt_tmr;
    logic [3:0]  bit_ff, nxt_bit, chr_ff, nxt_chr;
    logic [7:0]  sh_ff, nxt_sh;
    logic [63:0] ser_ff, nxt_ser;      // serial value
    logic [63:0] cnt_ff, nxt_cnt;      // up/down pulse counter
    logic        req_ff, nxt_req;
    logic        push;
    logic [7:0]  fifo_out;
    logic        fifo_valid, fifo_in_ready;
    logic [63:0] pos_ff;
    logic        pv_ff;
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {a1_ff, a2_ff, a3_ff} <= 3'b111;
            {b1_ff, b2_ff, b3_ff} <= 3'b000;
        end
        else
        begin
            a1_ff <= link.quad_out_a;
            a2_ff <= a1_ff;
            a3_ff <= a2_ff;
            b1_ff <= link.quad_out_b;
            b2_ff <= b1_ff;
            b3_ff <= b2_ff;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        nxt_st  = st_ff;
        nxt_tmr = (tmr_ff == 32'h0) ? tmr_ff : tmr_ff - 32'h1;
        nxt_bit = bit_ff;
        nxt_chr = chr_ff;
        nxt_sh  = sh_ff;
        nxt_ser = ser_ff;
        nxt_cnt = cnt_ff;
        nxt_req = req_ff;
        push    = 1'b0;
        unique case (st_ff)
            HS_IDLE:
                if (start)
                begin
                    nxt_req = 1'b1;
                    nxt_tmr = 32'(WAIT_CYC);
                    nxt_st  = HS_WAIT;
                end
            HS_WAIT:
                if (tmr_ff == 32'h0)
                begin
                    nxt_cnt = 64'h0;
                    nxt_ser = 64'h0;
                    nxt_chr = 4'h0;
                    nxt_bit = 4'h0;
                    nxt_st  = HS_RX;
                end
            HS_RX:
                // find start bit once into the stop bit, sample mid-bit, stall if fifo full
                if (bit_ff == 4'h0)
                begin
                    if (!a2_ff && fifo_in_ready && tmr_ff == 32'h0)
                    begin
                        nxt_bit = 4'h1;
                        nxt_tmr = 32'(BIT_CYC + BIT_CYC / 2);
                    end
                end
                else if (tmr_ff == 32'h0)
                begin
                    nxt_sh  = {a2_ff, sh_ff[7:1]};
                    nxt_tmr = 32'(BIT_CYC);
                    nxt_bit = bit_ff + 4'h1;
                    if (bit_ff == 4'h8)
                    begin
                        push    = 1'b1;
                        nxt_bit = 4'h0;
                        nxt_tmr = 32'(BIT_CYC / 2);
                        nxt_ser = {nxt_sh, ser_ff[63:8]};
                        nxt_chr = chr_ff + 4'h1;
                        if (chr_ff == `EPO_CHAR_COUNT - 4'h1)
                            nxt_st = HS_PULSE;
                    end
                end
            HS_PULSE:
            begin
                // count rising edges of a as initial pulses
                if (a2_ff && !a3_ff && tmr_ff == 32'h0)
                    nxt_cnt = cnt_ff + 64'h1;
                if (b2_ff != b3_ff)
                    nxt_st = HS_RUN;
            end
            HS_RUN:
            begin
                // x4 decode; origin pulse deliberately not used for reset
                if (a2_ff != a3_ff || b2_ff != b3_ff)
                    nxt_cnt = ((a2_ff ^ b3_ff) == 1'b0) ? cnt_ff + 64'h1 : cnt_ff - 64'h1;
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff  <= HS_IDLE;
            tmr_ff <= 32'h0;
            bit_ff <= 4'h0;
            chr_ff <= 4'h0;
            sh_ff  <= 8'h00;
            ser_ff <= 64'h0;
            cnt_ff <= 64'h0;
            req_ff <= 1'b0;
            pos_ff <= 64'h0;
            pv_ff  <= 1'b0;
        end
        else
        begin
            st_ff  <= nxt_st;
            tmr_ff <= nxt_tmr;
            bit_ff <= nxt_bit;
            chr_ff <= nxt_chr;
            sh_ff  <= nxt_sh;
            ser_ff <= nxt_ser;
            cnt_ff <= nxt_cnt;
            req_ff <= nxt_req;
            // position = serial*R + pulses - ref serial*R - ref pulses
            pos_ff <= (ser_ff << 20) + cnt_ff - (ref_serial << 20)
                      - {32'h0, ref_pulses};
            pv_ff  <= (st_ff == HS_PULSE) || (st_ff == HS_RUN);
        end
    end
    // received characters for software
    epo_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (nxt_sh),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (rx_byte_ready)
    );
    assign link.absolute_data_request = req_ff;
    assign user_position  = pos_ff;
    assign position_valid = pv_ff;
    assign rx_byte        = fifo_out;
    assign rx_byte_valid  = fifo_valid;
endmodule
`default_nettype wire

//--- rtl/epo_link_if.sv
// link between device and host: quadrature, origin and request lines
// assumes both ends on the same clock
`timescale 1ns/1ns
`default_nettype none
interface epo_link_if;
    logic quad_out_a;             // channel a, serial data at init
    logic quad_out_b;             // channel b
    logic origin_pulse_out;       // channel c
    logic absolute_data_request;  // host request line
    modport device (output quad_out_a, output quad_out_b, output origin_pulse_out,
                    input absolute_data_request);
    modport host   (input quad_out_a, input quad_out_b, input origin_pulse_out,
                    output absolute_data_request);
endinterface
`default_nettype wire

//--- rtl/epo_pkg.sv
// types shared by both ends of the encoder pulse output link
// assumes the defines header is compiled alongside
package epo_pkg;
    // where the origin pulse is aligned
    typedef enum logic [1:0] {EPO_ALIGN_A_RISE, EPO_ALIGN_A_FALL,
                              EPO_ALIGN_B_RISE, EPO_ALIGN_B_FALL} epo_align_t;
endpackage

//--- verification/epo_props.sv
// link checker: watches the four wires between device and host
// assumes one clock and one request per reset
`timescale 1ns/1ns
`default_nettype none
module epo_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic quad_out_a,
    input wire logic quad_out_b,
    input wire logic origin_pulse_out,
    input wire logic absolute_data_request
);
    logic       org_d_ff;  // origin one cycle ago
    logic [1:0] cnt_ff;    // origin rises, saturating
    logic [1:0] nxt_cnt;   // next rise count
    // count origin rises, stop at three
    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (origin_pulse_out && !org_d_ff && cnt_ff != 2'h3)
            nxt_cnt = cnt_ff + 2'h1;
    end
    // register the count and the delayed origin
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff   <= 2'h0;
            org_d_ff <= 1'b0;
        end
        else
        begin
            cnt_ff   <= nxt_cnt;
            org_d_ff <= origin_pulse_out;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_levels: assert property ($fell(rst) |-> quad_out_a && !quad_out_b
        && !origin_pulse_out) else $error("link not idle after reset");
    a_req_held: assert property ($rose(absolute_data_request) |=>
        absolute_data_request[*8]) else $error("request dropped");
    a_start_bit: assert property ($rose(absolute_data_request) |-> ##[1:8]
        !quad_out_a) else $error("no start bit");
    a_b_quiet_init: assert property ($rose(absolute_data_request) |->
        !quad_out_b[*8]) else $error("channel b moved during init");
    a_quad_single: assert property (!($changed(quad_out_a)
        && $changed(quad_out_b))) else $error("a and b changed together");
    a_origin_aligned: assert property ($rose(origin_pulse_out) |->
        $changed(quad_out_a) || $changed(quad_out_b)) else $error("origin off edge");
    a_origin_width: assert property ($fell(origin_pulse_out) |->
        $fell(quad_out_a)) else $error("origin width not an a pulse");
    a_origin_once: assert property (cnt_ff <= 2'h1) else $error("origin repeated");
    c_request: cover property ($rose(absolute_data_request));
    c_origin: cover property ($rose(origin_pulse_out));
    c_quad_b: cover property ($changed(quad_out_b));
endmodule
`default_nettype wire

//--- verification/testbench.sv
// bench: device and host joined by the link, serial then quadrature
// assumes package, header and interface compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench import epo_pkg::*;;
    logic clk, rst, rds, abs_enc, step, sin_lead, org, start, rdy, watch, exp_fwd;
    logic rate_alarm, normal_mode, usage_error, pos_valid, rx_valid, a_d, b_d, c_d;
    logic [1:0]  usage;     // encoder sense setting
    logic [31:0] abs_pos;   // absolute position at request
    logic [63:0] user_pos;  // host's rebuilt position
    logic [7:0]  rx_byte;   // received character
    int miscompares = 0, tests_run = 0, cycles = 0, org_rises = 0, dir_bad = 0, edges = 0;
    epo_link_if link ();
    epo_device #(.SETTLE_CYC(1000), .BIT_CYC(100)) epo_device_inst (.clk(clk), .rst(rst),
        .link(link), .rotation_direction_select(rds), .external_encoder_usage(usage),
        .origin_align(EPO_ALIGN_A_RISE), .absolute_encoder(abs_enc), .enc_step(step),
        .enc_sin_lead(sin_lead), .enc_origin(org), .abs_position(abs_pos),
        .rate_alarm(rate_alarm), .normal_mode(normal_mode), .usage_error(usage_error));
    epo_host #(.WAIT_CYC(20), .BIT_CYC(100)) epo_host_inst (.clk(clk), .rst(rst), .link(link),
        .start(start), .ref_serial(64'h0000_0000_0000_0001), .ref_pulses(32'h0000_0002),
        .user_position(user_pos), .position_valid(pos_valid), .rx_byte(rx_byte),
        .rx_byte_valid(rx_valid), .rx_byte_ready(rdy));
    epo_props epo_props_inst (.clk(clk), .rst(rst), .quad_out_a(link.quad_out_a),
        .quad_out_b(link.quad_out_b), .origin_pulse_out(link.origin_pulse_out),
        .absolute_data_request(link.absolute_data_request));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // edge watcher: phase order, edge count, origin rises, watchdog
    always @(negedge clk)
    begin
        if (watch && link.quad_out_b !== b_d && (link.quad_out_a !== link.quad_out_b) !== exp_fwd)
            dir_bad++;
        if (watch && link.quad_out_a !== a_d && (link.quad_out_a === link.quad_out_b) !== exp_fwd)
            dir_bad++;
        if (watch && (link.quad_out_a !== a_d || link.quad_out_b !== b_d))
            edges++;
        if (link.origin_pulse_out === 1'b1 && c_d !== 1'b1)
            org_rises++;
        a_d = link.quad_out_a;
        b_d = link.quad_out_b;
        c_d = link.origin_pulse_out;
        cycles++;
        if (cycles > 40_000)
        begin
            miscompares++;
            complete_run();
        end
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
    begin
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task complete_run;
    begin
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    // one origin pulse, then n pitches in one sense with a gap
    task automatic steps(input logic fwd, input int n, input int gap);
    begin
        @(posedge clk) #1 sin_lead = ~fwd;
        exp_fwd = fwd;
        dir_bad = 0;
        edges = 0;
        watch = 1'b1;
        org = 1'b1;
        @(posedge clk) #1 org = 1'b0;
        repeat (n)
        begin
            @(posedge clk) #1 step = 1'b1;
            @(posedge clk) #1 step = 1'b0;
            repeat (gap) @(posedge clk);
        end
        watch = 1'b0;
    end
    endtask
    // request, eight characters held in the fifo, then drained
    task automatic t_absolute;
    begin
        @(posedge clk) #1 start = 1'b1;
        @(posedge clk) #1 start = 1'b0;
        wait (normal_mode === 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            check(rx_valid, 1);
            check(rx_byte, (i == 0) ? 8'h03 : 8'h00);
            @(posedge clk) #1 rdy = 1'b1;
            @(posedge clk) #1 rdy = 1'b0;
        end
    end
    endtask
    // forward then reverse motion, position, origin, then overspeed
    task automatic t_motion;
    begin
        steps(1'b1, 3, 600);
        check(dir_bad, 0);
        check(edges, 60);
        wait (pos_valid === 1'b1);
        check(user_pos, 64'h0000_0000_0020_003F);
        check(rate_alarm, 0);
        check(usage_error, 0);
        steps(1'b0, 2, 600);
        check(dir_bad, 0);
        check(edges, 40);
        check(org_rises, 1);
        steps(1'b1, 8, 0);
        repeat (400) @(posedge clk);
        check(rate_alarm, 1);
    end
    endtask
    initial
    begin
        {rst, abs_enc, sin_lead} = 3'h7;
        {rds, step, org, start, rdy, watch, exp_fwd} = 7'h00;
        usage = 2'h1;
        abs_pos = 32'h0030_0005;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        @(negedge clk);
        check({link.quad_out_a, link.quad_out_b, link.origin_pulse_out}, 3'h4);
        t_absolute();
        t_motion();
        complete_run();
    end
endmodule
`default_nettype wire
